// ---- rtl/dvitx_input_ctrl.sv ----
// Input control of a DVI transmitter: pixel capture, detect, DE generator
`timescale 1ns/1ps

// Overview of operation
// - 24-bit pixel: red on top byte, green middle, blue lowest byte.
// - De-skew enable picks coded sampling offset, else fixed default offset.
// - Offset equals code minus four, in whole steps, minus four to plus three.
// - Only the data capture instant moves; pixel clock itself untouched.
// - De-skew settings from straps without serial access, else registers.
// - Receiver-sense status bit shows an attached receiver.
// - Hot-plug status bit follows the hot-plug input level.
// - Without serial access, receiver sense drives the monitor-sense pin.
// - With serial access, select field routes hot-plug, sense, irq or off.
// - Source select picks watched signal; any change sets interrupt status.
// - Interrupt status sticks until software writes one; zero does nothing.
// - Select pin low: configuration from straps, serial access disabled.
// - Select pin high: configuration from register bits, serial enabled.
// - Low pulse on select pin returns all registers but the measured counts to defaults.
// - Generator enabled: internal data-enable replaces external input.
// - Generated enable starts lines after vsync, lasts programmed lines.
// - Within line, starts pixels after hsync, lasts programmed pixels.
// - Lines per frame and pixels per line counted while powered up, always readable.
// - Single-byte accesses only; each byte addressed on its own.
// - Slave address 0111, three pin bits, then read/write bit.
// - Power-down bit zero powers down and is the reset value.
module dvitx_input_ctrl
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [dvitx_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cfg_select_reset_i,
  input wire logic [2:0] slave_addr_sel_i,
  input wire logic hot_plug_level_i,
  input wire logic receiver_sense_i,
  input wire logic strap_bus_width_select_i,
  input wire logic strap_clock_type_select_i,
  input wire logic strap_edge_i,
  input wire logic strap_power_down_n_i,
  input wire logic strap_deskew_enable_i,
  input wire logic [2:0] strap_deskew_code_i,
  input wire logic pixel_in_clock_i,
  input wire logic [23:0] pixel_data_i,
  input wire logic den_i,
  input wire logic hsync_i,
  input wire logic vsync_i,
  output dvitx_pkg::dvitx_pixel_t pixel_o,
  output logic pixel_valid_o,
  output logic den_o,
  output logic hsync_o,
  output logic vsync_o,
  output logic monitor_sense_out_o,
  output logic monitor_sense_oe_o,
  output logic bus_width_select_o,
  output logic clock_type_select_o,
  output logic edge_o,
  output logic power_down_n_o,
  output logic [7:0] slave_address_o
);
  localparam int TAP_W = $clog2(dvitx_pkg::HIST_N);

  dvitx_pkg::dvitx_state_t q;
  dvitx_pkg::dvitx_state_t n;
  dvitx_pkg::dvitx_pins_t pin_w;
  dvitx_pkg::dvitx_sample_t smp;
  logic ser;
  logic pclk_edge;
  logic cap;
  logic [2:0] code;
  logic [TAP_W-1:0] tap;
  logic req;
  logic wr;
  logic [7:0] idx;
  logic [7:0] d;
  logic hs_act;
  logic vs_act;
  logic hs_start;
  logic vs_start;
  logic [10:0] pcount_nxt;
  logic [10:0] lcount_nxt;
  logic lwin;
  logic pwin;
  logic chg;
  logic w1c;

  // Gather every asynchronous pin into one sampled vector
  // red top, blue lowest
  assign pin_w = {cfg_select_reset_i, slave_addr_sel_i, hot_plug_level_i,
    receiver_sense_i, strap_bus_width_select_i, strap_clock_type_select_i,
    strap_edge_i, strap_power_down_n_i, strap_deskew_enable_i,
    strap_deskew_code_i, pixel_in_clock_i, vsync_i, hsync_i, den_i,
    pixel_data_i};

  // Bus decode
  assign req = wb_cyc_i & wb_stb_i & ~q.ack;
  // low byte lane only, committed on the acknowledged edge
  assign wr = wb_cyc_i & wb_stb_i & q.ack & wb_we_i & wb_sel_i[0];
  assign idx = wb_adr_i[dvitx_pkg::ADR_W-1:2];
  assign d = wb_dat_i[7:0];

  // Serial access follows the filtered select pin
  assign ser = q.stb.cfg_sel;

  // Latching edge of the filtered pixel clock
  // clock only observed, never altered
  assign pclk_edge = (q.s3.pclk == q.s2.pclk) && (q.s3.pclk != q.stb.pclk)
    && (q.s3.pclk == q.cfg.edge_rise);

  assign code = q.cfg.dk_en ? q.cfg.dk_code : dvitx_pkg::DK_DEFAULT;
  // tap distance is (code - 4) steps around the edge
  assign tap = TAP_W'((dvitx_pkg::DK_SPAN - int'(code))
    * dvitx_pkg::STEP_CYC);
  assign cap = q.edly[dvitx_pkg::LEAD-1] & q.cfg.pd_n;
  assign smp = q.hist[tap];

  // Sync activity from the programmed polarities
  // vsync polarity
  assign vs_act = smp.vsync == q.regs.vpol;
  assign hs_act = smp.hsync == q.regs.hpol;
  assign hs_start = hs_act & ~q.hs_prev;
  assign vs_start = vs_act & ~q.vs_prev;

  // Line and pixel counters, saturating
  assign pcount_nxt = hs_start ? 11'h000 :
    (&q.pcount ? q.pcount : q.pcount + 11'h001);
  assign lcount_nxt = vs_start ? 11'h000 :
    (hs_start && !(&q.lcount) ? q.lcount + 11'h001 : q.lcount);

  // Generator windows
  // line window
  assign lwin = ({5'h00, q.regs.line_start} <= {1'b0, lcount_nxt})
    && ({1'b0, lcount_nxt} < 12'({5'h00, q.regs.line_start}
    + {1'b0, q.regs.line_len}));
  assign pwin = ({3'h0, q.regs.pix_start} <= {1'b0, pcount_nxt})
    && ({1'b0, pcount_nxt} < 12'({3'h0, q.regs.pix_start}
    + {1'b0, q.regs.pix_len}));

  // Detect change and clear request
  // change of chosen signal
  // Filtered level flips once both late stages disagree with it
  assign chg = q.regs.irq_source_select
    ? (q.s2.rsense == q.s3.rsense && q.s3.rsense != q.stb.rsense)
    : (q.s2.hot_plug == q.s3.hot_plug && q.s3.hot_plug != q.stb.hot_plug);
  assign w1c = wr && idx == dvitx_pkg::IDX_DET && d[dvitx_pkg::DET_IRQ];

  // Next-state logic of the whole block
  always_comb
  begin
    n = q;
    n.s1 = pin_w;
    n.s2 = q.s1;
    n.s3 = q.s2;
    // Level counts once second and third stage agree
    n.stb = (q.s2 & q.s3) | (q.stb & (q.s2 | q.s3));
    n.hist = {q.hist[dvitx_pkg::HIST_N-2:0], q.stb.smp};
    n.edly = {q.edly[dvitx_pkg::LEAD-2:0], pclk_edge};
    // fixed upper nibble, pin bits, write direction
    n.saddr = {dvitx_pkg::SLAVE_ADDR_HI, q.stb.addr_sel, 1'b0};

    // de-skew source follows the same select
    n.cfg = ser ? q.regs.mode : q.stb.strap;

    // Pixel capture at the shifted sampling instant
    n.pvalid = cap;
    if (cap)
    begin
      n.out = smp;
      n.hs_prev = hs_act;
      n.vs_prev = vs_act;
      n.pcount = pcount_nxt;
      n.lcount = lcount_nxt;
      n.out.den = q.regs.gen ? (lwin & pwin) : smp.den;
      if (hs_start)
      begin
        n.meas_pix = q.pcount + 11'h001;
      end
      if (vs_start)
      begin
        // Line holding the vsync start counts as well
        n.meas_lin = q.lcount + 11'h001;
      end
    end

    n.regs.irq = chg | (q.regs.irq & ~w1c);

    // Register writes, one byte each
    if (wr)
    begin
      unique case (idx)
        dvitx_pkg::IDX_MODE:
        begin
          n.regs.mode.pd_n = d[dvitx_pkg::MODE_PD];
          n.regs.mode.edge_rise = d[dvitx_pkg::MODE_EDGE];
          n.regs.mode.bus_width_select = d[dvitx_pkg::MODE_BUS_WIDTH_SELECT];
          n.regs.mode.clock_type_select = d[dvitx_pkg::MODE_CLOCK_TYPE_SELECT];
        end
        dvitx_pkg::IDX_DET:
        begin
          n.regs.irq_source_select = d[dvitx_pkg::DET_IRQ_SOURCE_SELECT];
          n.regs.sense_out_select = dvitx_pkg::dvitx_sense_out_select_t'(d[dvitx_pkg::DET_SENSE_OUT_SELECT+:3]);
        end
        dvitx_pkg::IDX_DSK:
        begin
          n.regs.mode.dk_en = d[dvitx_pkg::DSK_EN];
          n.regs.mode.dk_code = d[dvitx_pkg::DSK_CODE+:3];
        end
        dvitx_pkg::IDX_PIX_START: n.regs.pix_start[7:0] = d;
        dvitx_pkg::IDX_DEN_CTRL:
        begin
          n.regs.pix_start[8] = d[dvitx_pkg::DEN_PIX8];
          n.regs.hpol = d[dvitx_pkg::DEN_HPOL];
          n.regs.vpol = d[dvitx_pkg::DEN_VPOL];
          n.regs.gen = d[dvitx_pkg::DEN_GEN];
        end
        dvitx_pkg::IDX_LINE_START: n.regs.line_start = d[6:0];
        dvitx_pkg::IDX_PIX_LEN_LO: n.regs.pix_len[7:0] = d;
        dvitx_pkg::IDX_PIX_LEN_HI: n.regs.pix_len[10:8] = d[2:0];
        dvitx_pkg::IDX_LINE_LEN_LO: n.regs.line_len[7:0] = d;
        dvitx_pkg::IDX_LINE_LEN_HI: n.regs.line_len[10:8] = d[2:0];
        default: n.regs = n.regs;
      endcase
    end

    // Register reads, unmapped read as zero
    n.ack = req;
    if (req && !wb_we_i)
    begin
      n.rdat = 32'h0000_0000;
      unique case (idx)
        dvitx_pkg::IDX_MODE: n.rdat[3:0] = {q.regs.mode.clock_type_select,
          q.regs.mode.bus_width_select, q.regs.mode.edge_rise, q.regs.mode.pd_n};
        dvitx_pkg::IDX_DET:
        begin
          n.rdat[dvitx_pkg::DET_IRQ] = q.regs.irq;
          n.rdat[dvitx_pkg::DET_HPLG] = q.stb.hot_plug;
          n.rdat[dvitx_pkg::DET_RECEIVER_SENSE] = q.stb.rsense;
          n.rdat[dvitx_pkg::DET_IRQ_SOURCE_SELECT] = q.regs.irq_source_select;
          n.rdat[dvitx_pkg::DET_SENSE_OUT_SELECT+:3] = q.regs.sense_out_select;
        end
        dvitx_pkg::IDX_DSK: n.rdat[7:4] = {q.regs.mode.dk_code,
          q.regs.mode.dk_en};
        dvitx_pkg::IDX_PIX_START: n.rdat[7:0] = q.regs.pix_start[7:0];
        dvitx_pkg::IDX_DEN_CTRL: n.rdat[6:0] = {q.regs.gen, q.regs.vpol,
          q.regs.hpol, 3'h0, q.regs.pix_start[8]};
        dvitx_pkg::IDX_LINE_START: n.rdat[6:0] = q.regs.line_start;
        dvitx_pkg::IDX_PIX_LEN_LO: n.rdat[7:0] = q.regs.pix_len[7:0];
        dvitx_pkg::IDX_PIX_LEN_HI: n.rdat[2:0] = q.regs.pix_len[10:8];
        dvitx_pkg::IDX_LINE_LEN_LO: n.rdat[7:0] = q.regs.line_len[7:0];
        dvitx_pkg::IDX_LINE_LEN_HI: n.rdat[2:0] = q.regs.line_len[10:8];
        dvitx_pkg::IDX_MPIX_LO: n.rdat[7:0] = q.meas_pix[7:0];
        dvitx_pkg::IDX_MPIX_HI: n.rdat[2:0] = q.meas_pix[10:8];
        dvitx_pkg::IDX_MLIN_LO: n.rdat[7:0] = q.meas_lin[7:0];
        dvitx_pkg::IDX_MLIN_HI: n.rdat[2:0] = q.meas_lin[10:8];
        default: n.rdat = 32'h0000_0000;
      endcase
    end

    // Monitor-sense pin routing
    // receiver sense while serial access off
    n.ms_oe = 1'b1;
    n.ms_out = q.stb.rsense;
    if (ser)
    begin
      unique case (q.regs.sense_out_select)
        dvitx_pkg::DVITX_MS_IRQ: n.ms_out = q.regs.irq;
        dvitx_pkg::DVITX_MS_RECEIVER_SENSE: n.ms_out = q.stb.rsense;
        dvitx_pkg::DVITX_MS_HPLG: n.ms_out = q.stb.hot_plug;
        default:
        begin
          n.ms_out = 1'b0;
          n.ms_oe = 1'b0;
        end
      endcase
    end

    // select pin low holds registers at defaults
    if (!ser)
    begin
      n.regs = dvitx_pkg::REGS_RST;
    end
    if (rst_i)
    begin
      n = dvitx_pkg::ST_RST;
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    q <= n;
  end

  // Outputs straight from state
  assign wb_dat_o = q.rdat;
  assign wb_ack_o = q.ack;
  assign pixel_o = q.out.pix;
  assign pixel_valid_o = q.pvalid;
  assign den_o = q.out.den;
  assign hsync_o = q.out.hsync;
  assign vsync_o = q.out.vsync;
  assign monitor_sense_out_o = q.ms_out;
  assign monitor_sense_oe_o = q.ms_oe;
  assign bus_width_select_o = q.cfg.bus_width_select;
  assign clock_type_select_o = q.cfg.clock_type_select;
  assign edge_o = q.cfg.edge_rise;
  assign power_down_n_o = q.cfg.pd_n;
  assign slave_address_o = q.saddr;

  // Checks on the block's own behaviour
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_edge_on;
    pclk_edge && q.cfg.pd_n;
  endsequence
  sequence s_stay_on;
    q.cfg.pd_n [*4];
  endsequence

  a_capture_delay: assert property (
    s_edge_on ##1 s_stay_on |=> pixel_valid_o)
    else $error("capture not four cycles after clock edge");
  a_deskew_tap: assert property (
    cap |=> pixel_o == $past(q.hist[tap].pix))
    else $error("pixel not taken from de-skew tap");
  a_default_tap: assert property (
    cap && !q.cfg.dk_en |=> pixel_o == $past(q.hist[4].pix))
    else $error("default de-skew not centred");
  a_pd_stops: assert property (
    !q.cfg.pd_n |=> !pixel_valid_o)
    else $error("capture during power-down");
  a_irq_sticky: assert property (
    q.regs.irq && ser && !w1c |=> q.regs.irq)
    else $error("interrupt status lost without clear");
  a_irq_set: assert property (
    ser && chg |=> q.regs.irq)
    else $error("detect change did not set status");
  a_sense_strap: assert property (
    !ser |=> monitor_sense_oe_o && monitor_sense_out_o == $past(q.stb.rsense))
    else $error("monitor sense not receiver sense");
  a_cfg_default: assert property (
    !ser |=> q.regs == dvitx_pkg::REGS_RST)
    else $error("registers not at defaults");
  a_strap_cfg: assert property (
    !ser |=> power_down_n_o == $past(q.stb.strap.pd_n))
    else $error("strap power-down not used");
  a_ext_den: assert property (
    cap && !q.regs.gen |=> den_o == $past(smp.den))
    else $error("external enable not passed");
  a_gen_window: assert property (
    cap && q.regs.gen && !(lwin && pwin) |=> !den_o)
    else $error("generated enable outside windows");
  a_hres_meas: assert property (
    cap && hs_start |=> q.meas_pix == $past(q.pcount) + 11'h001)
    else $error("pixel count not latched");
  a_bus_ack: assert property (
    req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not one cycle after request");
endmodule : dvitx_input_ctrl

// ---- rtl/dvitx_pkg.sv ----
// Shared types and constants for the DVI transmitter input control block
package dvitx_pkg;
  // Clock and de-skew timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int DESKEW_STEP_NS = 10;
  localparam int STEP_CYC = (DESKEW_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DK_SPAN = 8;
  localparam int DK_MID = 4;
  localparam int HIST_N = DK_SPAN * STEP_CYC + 1;
  localparam int LEAD = DK_MID * STEP_CYC;
  localparam logic [2:0] DK_DEFAULT = 3'h4;
  // Bus and serial address
  localparam int ADR_W = 10;
  localparam logic [3:0] SLAVE_ADDR_HI = 4'h7;
  // Register indices, byte address is four times the index
  localparam logic [7:0] IDX_MODE = 8'h08;
  localparam logic [7:0] IDX_DET = 8'h09;
  localparam logic [7:0] IDX_DSK = 8'h0A;
  localparam logic [7:0] IDX_PIX_START = 8'h32;
  localparam logic [7:0] IDX_DEN_CTRL = 8'h33;
  localparam logic [7:0] IDX_LINE_START = 8'h34;
  localparam logic [7:0] IDX_PIX_LEN_LO = 8'h36;
  localparam logic [7:0] IDX_PIX_LEN_HI = 8'h37;
  localparam logic [7:0] IDX_LINE_LEN_LO = 8'h38;
  localparam logic [7:0] IDX_LINE_LEN_HI = 8'h39;
  localparam logic [7:0] IDX_MPIX_LO = 8'h3A;
  localparam logic [7:0] IDX_MPIX_HI = 8'h3B;
  localparam logic [7:0] IDX_MLIN_LO = 8'h3C;
  localparam logic [7:0] IDX_MLIN_HI = 8'h3D;
  // Field positions
  localparam int MODE_PD = 0;
  localparam int MODE_EDGE = 1;
  localparam int MODE_BUS_WIDTH_SELECT = 2;
  localparam int MODE_CLOCK_TYPE_SELECT = 3;
  localparam int DET_IRQ = 0;
  localparam int DET_HPLG = 1;
  localparam int DET_RECEIVER_SENSE = 2;
  localparam int DET_IRQ_SOURCE_SELECT = 3;
  localparam int DET_SENSE_OUT_SELECT = 4;
  localparam int DSK_EN = 4;
  localparam int DSK_CODE = 5;
  localparam int DEN_PIX8 = 0;
  localparam int DEN_HPOL = 4;
  localparam int DEN_VPOL = 5;
  localparam int DEN_GEN = 6;
  localparam logic [3:0] MODE_RESET = 4'hE;

  typedef enum logic [2:0] {
    DVITX_MS_OFF, DVITX_MS_IRQ, DVITX_MS_RECEIVER_SENSE, DVITX_MS_HPLG
  } dvitx_sense_out_select_t;
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } dvitx_pixel_t;
  typedef struct packed {
    logic vsync;
    logic hsync;
    logic den;
    dvitx_pixel_t pix;
  } dvitx_sample_t;
  typedef struct packed {
    logic bus_width_select;
    logic clock_type_select;
    logic edge_rise;
    logic pd_n;
    logic dk_en;
    logic [2:0] dk_code;
  } dvitx_cfg_t;
  typedef struct packed {
    logic cfg_sel;
    logic [2:0] addr_sel;
    logic hot_plug;
    logic rsense;
    dvitx_cfg_t strap;
    logic pclk;
    dvitx_sample_t smp;
  } dvitx_pins_t;
  typedef struct packed {
    dvitx_cfg_t mode;
    logic irq_source_select;
    dvitx_sense_out_select_t sense_out_select;
    logic irq;
    logic [8:0] pix_start;
    logic gen;
    logic vpol;
    logic hpol;
    logic [6:0] line_start;
    logic [10:0] pix_len;
    logic [10:0] line_len;
  } dvitx_regs_t;
  localparam dvitx_regs_t REGS_RST = '{
    mode: '{bus_width_select: MODE_RESET[MODE_BUS_WIDTH_SELECT], clock_type_select: MODE_RESET[MODE_CLOCK_TYPE_SELECT],
            edge_rise: MODE_RESET[MODE_EDGE], pd_n: MODE_RESET[MODE_PD],
            dk_en: 1'b0, dk_code: 3'h0},
    sense_out_select: DVITX_MS_OFF, default: '0};
  typedef struct packed {
    dvitx_pins_t s1;
    dvitx_pins_t s2;
    dvitx_pins_t s3;
    dvitx_pins_t stb;
    dvitx_sample_t [HIST_N-1:0] hist;
    logic [LEAD-1:0] edly;
    dvitx_regs_t regs;
    logic [10:0] pcount;
    logic [10:0] lcount;
    logic [10:0] meas_pix;
    logic [10:0] meas_lin;
    logic hs_prev;
    logic vs_prev;
    logic ack;
    logic [31:0] rdat;
    dvitx_cfg_t cfg;
    dvitx_sample_t out;
    logic pvalid;
    logic ms_out;
    logic ms_oe;
    logic [7:0] saddr;
  } dvitx_state_t;
  localparam dvitx_state_t ST_RST = '{regs: REGS_RST, default: '0};
endpackage : dvitx_pkg

// ---- verification/dvitx_gfx_model.sv ----
// Graphics controller model: pixel clock, pixel bus and sync raster
`timescale 1ns/1ps
module dvitx_gfx_model
(
  input wire logic clk_i,
  input wire logic rst_i,
  output logic pclk_o,
  output logic [23:0] data_o,
  output logic den_o,
  output logic hsync_o,
  output logic vsync_o
);
  localparam int H_TOT = 20;
  localparam int V_TOT = 6;
  logic [3:0] cnt;
  logic [7:0] hx;
  logic [7:0] vy;
  logic [7:0] hn;
  logic [7:0] vn;
  // Next raster position
  always_comb
  begin
    hn = (hx == H_TOT - 1) ? 8'h00 : hx + 8'h01;
    vn = vy;
    if (hx == H_TOT - 1)
      vn = (vy == V_TOT - 1) ? 8'h00 : vy + 8'h01;
  end
  // Period of 16 cycles; syncs move at fall, data late after rise
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt <= 4'h0;
      pclk_o <= 1'b0;
      hx <= 8'h00;
      vy <= 8'h00;
      data_o <= 24'h000000;
      {den_o, hsync_o, vsync_o} <= 3'h0;
    end
    else
    begin
      cnt <= cnt + 4'h1;
      if (cnt == 4'h7)
      begin
        pclk_o <= 1'b0;
        hsync_o <= (hn < 8'h04);
        vsync_o <= (vn == 8'h00);
        den_o <= (hn >= 8'h06) && (hn < 8'h10)
          && (vn >= 8'h01) && (vn < 8'h05);
      end
      if (cnt == 4'hF)
      begin
        pclk_o <= 1'b1;
        hx <= hn;
        vy <= vn;
      end
      if (cnt == 4'h0)
        data_o <= {8'hA5, vy, hx};
    end
  end
endmodule : dvitx_gfx_model

// ---- verification/testbench.sv ----
// Self-checking bench for the DVI transmitter input control block
`timescale 1ns/1ps
module testbench;
  logic clk_i, rst_i, cyc, stb, we, cfg_sel, hp, rs, s_pd, s_dk;
  logic [9:0] adr;
  logic [31:0] wdat, rdat;
  logic [3:0] sel;
  logic [2:0] asel, s_code;
  logic pclk, den, hs, vs, pval, den_o, hs_o, vs_o, ms_out, ms_oe, ack;
  logic bw, ct, edg, pdn, prev_hs, prev_vs, hs_go, vs_go;
  logic [23:0] pdata;
  logic [7:0] saddr, rd;
  dvitx_pkg::dvitx_pixel_t pix;
  int bad_count, tests_run, c, i;
  logic [7:0] dk_cfg [5] = '{8'hE0, 8'h10, 8'h70, 8'h90, 8'hF0};
  logic [7:0] dk_exp [5] = '{8'h13, 8'h13, 8'h13, 8'h13, 8'h00};

  dvitx_input_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .cfg_select_reset_i(cfg_sel), .slave_addr_sel_i(asel),
    .hot_plug_level_i(hp), .receiver_sense_i(rs),
    .strap_bus_width_select_i(1'b1), .strap_clock_type_select_i(1'b0),
    .strap_edge_i(1'b1), .strap_power_down_n_i(s_pd),
    .strap_deskew_enable_i(s_dk), .strap_deskew_code_i(s_code),
    .pixel_in_clock_i(pclk), .pixel_data_i(pdata), .den_i(den),
    .hsync_i(hs), .vsync_i(vs), .pixel_o(pix), .pixel_valid_o(pval),
    .den_o(den_o), .hsync_o(hs_o), .vsync_o(vs_o),
    .monitor_sense_out_o(ms_out), .monitor_sense_oe_o(ms_oe),
    .bus_width_select_o(bw), .clock_type_select_o(ct), .edge_o(edg),
    .power_down_n_o(pdn), .slave_address_o(saddr));
  dvitx_gfx_model GFX (.clk_i(clk_i), .rst_i(rst_i), .pclk_o(pclk),
    .data_o(pdata), .den_o(den), .hsync_o(hs), .vsync_o(vs));

  // Start of a captured line or frame
  assign hs_go = (pval === 1'b1) && (hs_o === 1'b1) && (prev_hs === 1'b0);
  assign vs_go = (pval === 1'b1) && (vs_o === 1'b1) && (prev_vs === 1'b0);
  always @(posedge clk_i)
    if (pval === 1'b1)
    begin
      prev_hs <= hs_o;
      prev_vs <= vs_o;
    end
  // Clock and watchdog
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial
  begin
    #600000;
    bad_count++;
    stop_test();
  end

  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask : chk
  task wait_clk(input int k);
    repeat (k) @(posedge clk_i);
  endtask : wait_clk
  // One single-byte Wishbone cycle, read byte left in rd
  task wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    {cyc, stb, we, sel} <= {2'b11, w, 4'hF};
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50)
    begin
      bad_count++;
      stop_test();
    end
  endtask : wb
  // Wait for the next captured line (v=0) or frame (v=1) start
  task wait_ev(input logic v);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while ((v ? vs_go : hs_go) !== 1'b1 && n < 8000);
    if (n >= 8000)
    begin
      bad_count++;
      stop_test();
    end
  endtask : wait_ev
  // Data-enable pixels captured over one frame
  task frame_den(output int cnt);
    wait_ev(1'b1);
    cnt = 0;
    do
    begin
      @(posedge clk_i);
      if (pval === 1'b1 && den_o === 1'b1)
        cnt++;
    end
    while (vs_go !== 1'b1);
  endtask : frame_den

  // Main sequence
  initial
  begin
    // de-skew strap grounded, reset held at power-up
    {rst_i, cyc, stb, we, cfg_sel, hp, rs, s_pd} = 8'h83;
    {adr, wdat, sel} = '0;
    {asel, s_dk, s_code} = 7'h57;
    {bad_count, tests_run} = '0;
    {prev_hs, prev_vs} = 2'b11;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_clk(10);
    chk(saddr, 8'h7A);
    asel <= 3'h0;
    wait_clk(8);
    chk(saddr, 8'h70);
    chk({ms_oe, ms_out}, 2'b11);
    rs <= 1'b0;
    wait_clk(8);
    chk({ms_oe, ms_out}, 2'b10);
    chk({bw, ct, edg, pdn}, 4'hB);
    wait_ev(1'b0);
    wait_ev(1'b0);
    chk({pix.red, pix.blue}, 16'hA513);
    s_pd <= 1'b0;
    wait_clk(8);
    chk(pdn, 1'b0);
    cfg_sel <= 1'b1;
    wait_clk(8);
    wb(1'b0, dvitx_pkg::IDX_MODE, 8'h00);
    chk(rd, 8'h0E);
    wb(1'b0, 8'h20, 8'h00);
    chk(rd, 8'h00);
    wb(1'b1, dvitx_pkg::IDX_MODE, 8'h0F);
    wb(1'b0, dvitx_pkg::IDX_MODE, 8'h00);
    chk({rd, pdn}, 9'h01F);
    for (i = 0; i < 5; i++)
    begin
      wb(1'b1, dvitx_pkg::IDX_DSK, dk_cfg[i]);
      wait_ev(1'b0);
      wait_ev(1'b0);
      chk({pix.red, pix.blue}, {8'hA5, dk_exp[i]});
    end
    wb(1'b1, dvitx_pkg::IDX_DEN_CTRL, 8'h30);
    frame_den(c);
    chk(c, 40);
    wb(1'b1, dvitx_pkg::IDX_PIX_START, 8'h0E);
    wb(1'b1, dvitx_pkg::IDX_LINE_START, 8'h02);
    wb(1'b1, dvitx_pkg::IDX_PIX_LEN_LO, 8'h05);
    wb(1'b1, dvitx_pkg::IDX_PIX_LEN_HI, 8'h00);
    wb(1'b1, dvitx_pkg::IDX_LINE_LEN_LO, 8'h02);
    wb(1'b1, dvitx_pkg::IDX_LINE_LEN_HI, 8'h00);
    wb(1'b1, dvitx_pkg::IDX_DEN_CTRL, 8'h70);
    frame_den(c);
    frame_den(c);
    chk(c, 10);
    wb(1'b0, dvitx_pkg::IDX_MPIX_LO, 8'h00);
    chk(rd, 8'h14);
    wb(1'b0, dvitx_pkg::IDX_MLIN_LO, 8'h00);
    chk(rd, 8'h06);
    wb(1'b0, dvitx_pkg::IDX_MLIN_HI, 8'h00);
    chk(rd, 8'h00);
    wb(1'b1, dvitx_pkg::IDX_DET, 8'h31);
    wb(1'b0, dvitx_pkg::IDX_DET, 8'h00);
    chk(rd, 8'h30);
    hp <= 1'b1;
    wait_clk(8);
    chk({ms_oe, ms_out}, 2'b11);
    wb(1'b0, dvitx_pkg::IDX_DET, 8'h00);
    chk(rd, 8'h33);
    wb(1'b1, dvitx_pkg::IDX_DET, 8'h30);
    wb(1'b0, dvitx_pkg::IDX_DET, 8'h00);
    chk(rd, 8'h33);
    wb(1'b1, dvitx_pkg::IDX_DET, 8'h31);
    wb(1'b0, dvitx_pkg::IDX_DET, 8'h00);
    chk(rd, 8'h32);
    wb(1'b1, dvitx_pkg::IDX_DET, 8'h19);
    wait_clk(3);
    chk({ms_oe, ms_out}, 2'b10);
    rs <= 1'b1;
    wait_clk(8);
    chk({ms_oe, ms_out}, 2'b11);
    wb(1'b1, dvitx_pkg::IDX_DET, 8'h29);
    wait_clk(3);
    chk({ms_oe, ms_out}, 2'b11);
    wb(1'b1, dvitx_pkg::IDX_DET, 8'h08);
    wait_clk(3);
    chk(ms_oe, 1'b0);
    cfg_sel <= 1'b0;
    wait_clk(4);
    cfg_sel <= 1'b1;
    wait_clk(8);
    wb(1'b0, dvitx_pkg::IDX_MODE, 8'h00);
    chk(rd, 8'h0E);
    stop_test();
  end
endmodule : testbench
